// file: shared/pcfg_pkg.sv
// Configuration-space map constants and carrier types.
// Assumes byte addresses on the config port, dword aligned.
`default_nettype none
package pcfg_pkg;
	// ----------------------------------------
	// Byte offsets
	// ----------------------------------------
	localparam logic [11:0] OFF_ID = 12'h000;
	localparam logic [11:0] OFF_CMD = 12'h004;
	localparam logic [11:0] OFF_CLASS = 12'h008;
	localparam logic [11:0] OFF_MISC = 12'h00C;
	localparam logic [11:0] OFF_BAR0 = 12'h010;
	localparam logic [11:0] OFF_BAR1 = 12'h014;
	localparam logic [11:0] OFF_SUBSYS = 12'h02C;
	localparam logic [11:0] OFF_CAPPTR = 12'h034;
	localparam logic [11:0] OFF_INTR = 12'h03C;
	localparam logic [11:0] OFF_PMCAP = 12'h080;
	localparam logic [11:0] OFF_PMDATA = 12'h084;
	localparam logic [11:0] OFF_MSICTL = 12'h08C;
	localparam logic [11:0] OFF_MSIADR = 12'h090;
	localparam logic [11:0] OFF_MSIUPR = 12'h094;
	localparam logic [11:0] OFF_MSIDAT = 12'h098;
	localparam logic [11:0] OFF_PDCTL = 12'h09C;
	localparam logic [11:0] OFF_PDVAL = 12'h0A0;
	localparam logic [11:0] OFF_VSCAP = 12'h0A4;
	localparam logic [11:0] OFF_PHY0 = 12'h0A8;
	localparam logic [11:0] OFF_PHY1 = 12'h0AC;
	localparam logic [11:0] OFF_TIMERS = 12'h0B0;
	localparam logic [11:0] OFF_EXPCAP = 12'h0E0;
	localparam logic [11:0] OFF_DEVCAP = 12'h0E4;
	localparam logic [11:0] OFF_DEVCTL = 12'h0E8;
	localparam logic [11:0] OFF_LNKCAP = 12'h0EC;
	localparam logic [11:0] OFF_LNKCTL = 12'h0F0;
	localparam logic [11:0] OFF_AERHDR = 12'h100;
	localparam logic [11:0] OFF_UNCSTS = 12'h104;
	localparam logic [11:0] OFF_CORSTS = 12'h110;
	localparam logic [11:0] OFF_CORMSK = 12'h114;
	localparam logic [11:0] OFF_AERCTL = 12'h118;
	localparam logic [11:0] OFF_HDRLOG = 12'h11C;
	localparam logic [11:0] OFF_HDRLOG_END = 12'h128;
	// ----------------------------------------
	// Capability chain
	// ----------------------------------------
	localparam logic [7:0] CAPID_PM = 8'h01;
	localparam logic [7:0] CAPID_MSI = 8'h05;
	localparam logic [7:0] CAPID_PD = 8'h03;
	localparam logic [7:0] CAPID_VS = 8'h09;
	localparam logic [7:0] CAPID_EXP = 8'h10;
	localparam logic [7:0] VS_LEN = 8'h28;
	localparam logic [15:0] EXTID_AER = 16'h0001;
	localparam logic [3:0] AER_VER = 4'h1;
	localparam logic [11:0] EXT_NEXT = 12'h000;
	// ----------------------------------------
	// Command and status field positions
	// ----------------------------------------
	localparam int CMD_IO = 0;
	localparam int CMD_MEM = 1;
	localparam int CMD_PAR = 6;
	localparam int CMD_SERR = 8;
	localparam int CMD_INTD = 10;
	localparam logic [15:0] CMD_WMASK = 16'h0543;
	localparam int STS_INT = 3;
	localparam int STS_CAP = 4;
	localparam logic [2:0] STS_RESET = 3'h0;
	localparam logic [31:0] ZERO32 = 32'h0000_0000;
	// ----------------------------------------
	// Carriers
	// ----------------------------------------
	typedef struct packed {
		logic valid;
		logic write;
		logic [11:0] addr;
		logic [3:0] be;
		logic [31:0] wdata;
	} pcfg_req_t;
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
	} pcfg_rsp_t;
	typedef struct packed {
		logic sigTargetAbort;
		logic fatalMsgSent;
		logic poisonedTlp;
		logic intPending;
		logic [31:0] uncorrSet;
		logic [31:0] corrSet;
		logic [3:0][31:0] tlpHeader;
	} pcfg_evt_t;
	typedef struct packed {
		logic ioEn;
		logic memEn;
		logic parityEn;
		logic serrEn;
		logic intDisable;
		logic msiEn;
		logic [1:0] powerState;
		logic [31:0] bar0;
		logic [31:0] bar1;
	} pcfg_ctl_t;
endpackage : pcfg_pkg
`default_nettype wire

// file: rtl/pcfg_w1c_bank.sv
// Sticky status bits, hardware set, host write-one clear.
// Assumes set and clear strobes are synchronous to mclk.
`default_nettype none
module pcfg_w1c_bank #(
	parameter int W = 32
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic [W-1:0] setBits,
	input wire logic [W-1:0] clrBits,
	output logic [W-1:0] bits
);
	typedef struct packed {
		logic [W-1:0] sticky;
	} pcfg_w1c_state_t;
	pcfg_w1c_state_t state_q, state_d;

	// Set beats clear so no event is lost
	for (genvar i = 0; i < W; i++) begin : g_bit
		always_comb begin
			state_d.sticky[i] = setBits[i] | (state_q.sticky[i] & ~clrBits[i]);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	assign bits = state_q.sticky;

	chk_set_wins: assert property (@(posedge mclk) disable iff (srst) (setBits != '0) |=> ((bits & $past(setBits)) == $past(setBits)))
		else $error("sticky bit lost its set");
endmodule : pcfg_w1c_bank
`default_nettype wire

// file: rtl/pcfg_id_load.sv
// Identification words with serial-memory autoload override.
// Assumes the loader presents one word per loadValid pulse.
`default_nettype none
module pcfg_id_load #(
	parameter logic [15:0] MAKER_DEFAULT = 16'h1A2B, // Arbitrary value
	parameter logic [15:0] PART_DEFAULT = 16'h3C4D, // Arbitrary value
	parameter logic [7:0] REV_DEFAULT = 8'h00
) (
	input wire logic mclk,
	input wire logic srst,
	input wire logic loadValid,
	input wire logic [1:0] loadSel,
	input wire logic [15:0] loadData,
	output logic [15:0] makerId,
	output logic [15:0] partId,
	output logic [7:0] revisionId
);
	typedef struct packed {
		logic [15:0] maker;
		logic [15:0] part;
		logic [7:0] rev;
	} pcfg_id_state_t;
	pcfg_id_state_t state_q, state_d;

	// Only the loader and reset change these; the host has no path in
	always_comb begin
		state_d = state_q;
		if (loadValid) begin
			case (loadSel)
				2'h0: state_d.maker = loadData;
				2'h1: state_d.part = loadData;
				2'h2: state_d.rev = loadData[7:0];
				default: state_d = state_q;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= '{maker: MAKER_DEFAULT, part: PART_DEFAULT, rev: REV_DEFAULT};
		end else begin
			state_q <= state_d;
		end
	end

	assign makerId = state_q.maker;
	assign partId = state_q.part;
	assign revisionId = state_q.rev;

	chk_id_autoload: assert property (@(posedge mclk) disable iff (srst) (loadValid && loadSel == 2'h0) |=> makerId == $past(loadData))
		else $error("maker id not taken from autoload");
endmodule : pcfg_id_load
`default_nettype wire

// file: rtl/pcfg_config_space.sv
// Configuration-space register bank of the link endpoint.
// Assumes one config request at a time, answered the next cycle.
`default_nettype none
module pcfg_config_space #(
	parameter logic [23:0] CLASS_CODE = 24'h070002,
	parameter logic [31:0] SUBSYSTEM = 32'h0000_0000,
	parameter logic [7:0] INT_PIN = 8'h01,
	parameter int BAR_SIZE_BITS = 12,
	parameter logic [31:0] DEV_CAP = 32'h0000_0000,
	parameter logic [31:0] LINK_CAP = 32'h0000_0011
) (
	input wire logic mclk,
	input wire logic srst,
	input wire pcfg_pkg::pcfg_req_t req,
	output pcfg_pkg::pcfg_rsp_t rsp,
	input wire logic loadValid,
	input wire logic [1:0] loadSel,
	input wire logic [15:0] loadData,
	input wire pcfg_pkg::pcfg_evt_t evt,
	output pcfg_pkg::pcfg_ctl_t ctl
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [15:0] cmd;
		logic [7:0] cacheLine;
		logic [31:0] bar0;
		logic [31:0] bar1;
		logic [7:0] intLine;
		logic [1:0] pmState;
		logic msiEn;
		logic [31:0] msiAddr;
		logic [31:0] msiUpper;
		logic [15:0] msiData;
		logic [15:0] pdAddr;
		logic [31:0] pdData;
		logic [31:0] phy0;
		logic [31:0] phy1;
		logic [31:0] timers;
		logic [15:0] devCtl;
		logic [15:0] linkCtl;
		logic [31:0] corrMask;
		logic [31:0] aerCtl;
		logic [3:0][31:0] hdrLog;
		logic ack;
		logic [31:0] rdata;
	} pcfg_state_t;
	pcfg_state_t state_q, state_d;

	localparam logic [31:0] BAR_MASK = ~((32'h1 << BAR_SIZE_BITS) - 32'h1);

	logic [15:0] makerId;
	logic [15:0] partId;
	logic [7:0] revisionId;
	logic [2:0] stsBits;
	logic [2:0] stsSet;
	logic [2:0] stsClr;
	logic [31:0] uncorrSts;
	logic [31:0] uncorrClr;
	logic [31:0] corrSts;
	logic [31:0] corrClr;
	logic [11:0] dwAddr;
	logic rdReq;
	logic wrReq;
	logic [31:0] rdVal;
	logic [31:0] wmask;

	assign dwAddr = {req.addr[11:2], 2'b00};
	assign rdReq = req.valid && !req.write;
	assign wrReq = req.valid && req.write;
	assign wmask = {{8{req.be[3]}}, {8{req.be[2]}}, {8{req.be[1]}}, {8{req.be[0]}}};

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw, input logic [31:0] m);
		merge = (old & ~m) | (nw & m);
	endfunction : merge

	// ----------------------------------------
	// Identification and sticky status
	// ----------------------------------------
	pcfg_id_load u_id (
		.mclk(mclk),
		.srst(srst),
		.loadValid(loadValid),
		.loadSel(loadSel),
		.loadData(loadData),
		.makerId(makerId),
		.partId(partId),
		.revisionId(revisionId)
	);

	// Signalled system error only counts while error reporting is enabled
	assign stsSet = {evt.poisonedTlp, evt.fatalMsgSent & state_q.cmd[pcfg_pkg::CMD_SERR], evt.sigTargetAbort};
	assign stsClr = (wrReq && dwAddr == pcfg_pkg::OFF_CMD) ? {req.wdata[31:30], req.wdata[27]} & {wmask[31:30], wmask[27]} : 3'h0;
	assign uncorrClr = (wrReq && dwAddr == pcfg_pkg::OFF_UNCSTS) ? req.wdata & wmask : pcfg_pkg::ZERO32;
	assign corrClr = (wrReq && dwAddr == pcfg_pkg::OFF_CORSTS) ? req.wdata & wmask : pcfg_pkg::ZERO32;

	pcfg_w1c_bank #(.W(3)) u_sts (
		.mclk(mclk),
		.srst(srst),
		.setBits(stsSet),
		.clrBits(stsClr),
		.bits(stsBits)
	);

	pcfg_w1c_bank #(.W(32)) u_uncorr (
		.mclk(mclk),
		.srst(srst),
		.setBits(evt.uncorrSet),
		.clrBits(uncorrClr),
		.bits(uncorrSts)
	);

	pcfg_w1c_bank #(.W(32)) u_corr (
		.mclk(mclk),
		.srst(srst),
		.setBits(evt.corrSet),
		.clrBits(corrClr),
		.bits(corrSts)
	);

	// ----------------------------------------
	// Read decode
	// ----------------------------------------
	always_comb begin
		rdVal = pcfg_pkg::ZERO32;
		case (dwAddr)
			pcfg_pkg::OFF_ID: rdVal = {partId, makerId};
			pcfg_pkg::OFF_CMD: rdVal = {stsBits[2:1], 2'b00, stsBits[0], 6'h00, 1'b1, evt.intPending, 3'h0,
				state_q.cmd & pcfg_pkg::CMD_WMASK};
			pcfg_pkg::OFF_CLASS: rdVal = {CLASS_CODE, revisionId};
			pcfg_pkg::OFF_MISC: rdVal = {16'h0000, 8'h00, state_q.cacheLine};
			pcfg_pkg::OFF_BAR0: rdVal = state_q.bar0;
			pcfg_pkg::OFF_BAR1: rdVal = state_q.bar1;
			pcfg_pkg::OFF_SUBSYS: rdVal = SUBSYSTEM;
			pcfg_pkg::OFF_CAPPTR: rdVal = {24'h000000, pcfg_pkg::OFF_PMCAP[7:0]};
			pcfg_pkg::OFF_INTR: rdVal = {16'h0000, INT_PIN, state_q.intLine};
			pcfg_pkg::OFF_PMCAP: rdVal = {16'h0003, pcfg_pkg::OFF_MSICTL[7:0], pcfg_pkg::CAPID_PM};
			pcfg_pkg::OFF_PMDATA: rdVal = {30'h0, state_q.pmState};
			pcfg_pkg::OFF_MSICTL: rdVal = {15'h0040, state_q.msiEn, pcfg_pkg::OFF_PDCTL[7:0], pcfg_pkg::CAPID_MSI};
			pcfg_pkg::OFF_MSIADR: rdVal = state_q.msiAddr;
			pcfg_pkg::OFF_MSIUPR: rdVal = state_q.msiUpper;
			pcfg_pkg::OFF_MSIDAT: rdVal = {16'h0000, state_q.msiData};
			pcfg_pkg::OFF_PDCTL: rdVal = {state_q.pdAddr, pcfg_pkg::OFF_VSCAP[7:0], pcfg_pkg::CAPID_PD};
			pcfg_pkg::OFF_PDVAL: rdVal = state_q.pdData;
			pcfg_pkg::OFF_VSCAP: rdVal = {8'h00, pcfg_pkg::VS_LEN, pcfg_pkg::OFF_EXPCAP[7:0], pcfg_pkg::CAPID_VS};
			pcfg_pkg::OFF_PHY0: rdVal = state_q.phy0;
			pcfg_pkg::OFF_PHY1: rdVal = state_q.phy1;
			pcfg_pkg::OFF_TIMERS: rdVal = state_q.timers;
			pcfg_pkg::OFF_EXPCAP: rdVal = {16'h0001, 8'h00, pcfg_pkg::CAPID_EXP};
			pcfg_pkg::OFF_DEVCAP: rdVal = DEV_CAP;
			pcfg_pkg::OFF_DEVCTL: rdVal = {16'h0000, state_q.devCtl};
			pcfg_pkg::OFF_LNKCAP: rdVal = LINK_CAP;
			pcfg_pkg::OFF_LNKCTL: rdVal = {16'h0011, state_q.linkCtl};
			pcfg_pkg::OFF_AERHDR: rdVal = {pcfg_pkg::EXT_NEXT, pcfg_pkg::AER_VER, pcfg_pkg::EXTID_AER};
			pcfg_pkg::OFF_UNCSTS: rdVal = uncorrSts;
			pcfg_pkg::OFF_CORSTS: rdVal = corrSts;
			pcfg_pkg::OFF_CORMSK: rdVal = state_q.corrMask;
			pcfg_pkg::OFF_AERCTL: rdVal = state_q.aerCtl;
			default: begin
				// Header log spans four dwords
				if (dwAddr >= pcfg_pkg::OFF_HDRLOG && dwAddr <= pcfg_pkg::OFF_HDRLOG_END) begin
					rdVal = state_q.hdrLog[2'(dwAddr[3:2] - pcfg_pkg::OFF_HDRLOG[3:2])];
				end
			end
		endcase
	end

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		state_d.ack = req.valid;
		state_d.rdata = rdReq ? rdVal : state_q.rdata;
		// First error is logged; later ones keep the earlier header
		if (evt.uncorrSet != pcfg_pkg::ZERO32 && uncorrSts == pcfg_pkg::ZERO32) begin
			state_d.hdrLog = evt.tlpHeader;
		end
		if (wrReq) begin
			case (dwAddr)
				pcfg_pkg::OFF_CMD: state_d.cmd = 16'(merge({16'h0000, state_q.cmd}, req.wdata,
					wmask & {16'h0000, pcfg_pkg::CMD_WMASK}));
				pcfg_pkg::OFF_MISC: state_d.cacheLine = 8'(merge({24'h0, state_q.cacheLine}, req.wdata, wmask));
				pcfg_pkg::OFF_BAR0: state_d.bar0 = merge(state_q.bar0, req.wdata, wmask & BAR_MASK);
				pcfg_pkg::OFF_BAR1: state_d.bar1 = merge(state_q.bar1, req.wdata, wmask & BAR_MASK);
				pcfg_pkg::OFF_INTR: state_d.intLine = 8'(merge({24'h0, state_q.intLine}, req.wdata, wmask));
				pcfg_pkg::OFF_PMDATA: state_d.pmState = 2'(merge({30'h0, state_q.pmState}, req.wdata, wmask));
				pcfg_pkg::OFF_MSICTL: state_d.msiEn = req.be[2] ? req.wdata[16] : state_q.msiEn;
				pcfg_pkg::OFF_MSIADR: state_d.msiAddr = merge(state_q.msiAddr, req.wdata, wmask & 32'hFFFF_FFFC);
				pcfg_pkg::OFF_MSIUPR: state_d.msiUpper = merge(state_q.msiUpper, req.wdata, wmask);
				pcfg_pkg::OFF_MSIDAT: state_d.msiData = 16'(merge({16'h0, state_q.msiData}, req.wdata, wmask));
				pcfg_pkg::OFF_PDCTL: state_d.pdAddr = 16'(merge({state_q.pdAddr, 16'h0}, req.wdata, wmask) >> 16);
				pcfg_pkg::OFF_PDVAL: state_d.pdData = merge(state_q.pdData, req.wdata, wmask);
				pcfg_pkg::OFF_PHY0: state_d.phy0 = merge(state_q.phy0, req.wdata, wmask);
				pcfg_pkg::OFF_PHY1: state_d.phy1 = merge(state_q.phy1, req.wdata, wmask);
				pcfg_pkg::OFF_TIMERS: state_d.timers = merge(state_q.timers, req.wdata, wmask);
				pcfg_pkg::OFF_DEVCTL: state_d.devCtl = 16'(merge({16'h0, state_q.devCtl}, req.wdata, wmask));
				pcfg_pkg::OFF_LNKCTL: state_d.linkCtl = 16'(merge({16'h0, state_q.linkCtl}, req.wdata, wmask));
				pcfg_pkg::OFF_CORMSK: state_d.corrMask = merge(state_q.corrMask, req.wdata, wmask);
				pcfg_pkg::OFF_AERCTL: state_d.aerCtl = merge(state_q.aerCtl, req.wdata, wmask);
				default: state_d.cmd = state_q.cmd;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			state_q <= '0;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign rsp.ack = state_q.ack;
	assign rsp.rdata = state_q.rdata;
	assign ctl.ioEn = state_q.cmd[pcfg_pkg::CMD_IO];
	assign ctl.memEn = state_q.cmd[pcfg_pkg::CMD_MEM];
	assign ctl.parityEn = state_q.cmd[pcfg_pkg::CMD_PAR];
	assign ctl.serrEn = state_q.cmd[pcfg_pkg::CMD_SERR];
	assign ctl.intDisable = state_q.cmd[pcfg_pkg::CMD_INTD];
	assign ctl.msiEn = state_q.msiEn;
	assign ctl.powerState = state_q.pmState;
	assign ctl.bar0 = state_q.bar0;
	assign ctl.bar1 = state_q.bar1;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	sequence sRead(logic [11:0] a);
		rdReq && dwAddr == a;
	endsequence
	sequence sFullWrite(logic [11:0] a);
		wrReq && dwAddr == a && req.be == 4'hF;
	endsequence

	chk_every_ack: assert property (req.valid |=> rsp.ack)
		else $error("request not answered next cycle");
	chk_id_word: assert property (sRead(pcfg_pkg::OFF_ID) |=> rsp.rdata == {partId, makerId})
		else $error("id word wrong");
	chk_id_readonly: assert property (sFullWrite(pcfg_pkg::OFF_ID) ##0 !loadValid |=> $stable(makerId) && $stable(partId))
		else $error("id changed by host write");
	chk_cap_start: assert property (sRead(pcfg_pkg::OFF_CAPPTR) |=> rsp.rdata == 32'h0000_0080)
		else $error("capability pointer wrong");
	chk_chain_end: assert property (sRead(pcfg_pkg::OFF_EXPCAP) |=> rsp.rdata[15:0] == 16'h0010)
		else $error("express capability not last");
	chk_ext_header: assert property (sRead(pcfg_pkg::OFF_AERHDR)
		|=> rsp.rdata[15:0] == 16'h0001 && (rsp.rdata[31:20] == 12'h000 || rsp.rdata[31:20] > 12'h0FF))
		else $error("extended header wrong");
	chk_uncorr_read: assert property (sRead(pcfg_pkg::OFF_UNCSTS) ##1 1'b1 |-> rsp.rdata == $past(uncorrSts))
		else $error("uncorrectable status misplaced");
	chk_mask_write: assert property (sFullWrite(pcfg_pkg::OFF_CORMSK) ##1 sRead(pcfg_pkg::OFF_CORMSK)
		|=> rsp.rdata == $past(req.wdata, 2))
		else $error("correctable mask not kept");
	chk_log_read: assert property (sRead(pcfg_pkg::OFF_HDRLOG) |=> rsp.rdata == $past(state_q.hdrLog[0]))
		else $error("header log misplaced");
	chk_reserved_zero: assert property (sRead(12'h018) |=> rsp.rdata == 32'h0000_0000)
		else $error("reserved dword not zero");
endmodule : pcfg_config_space
`default_nettype wire

// file: testbench/pcfg_root_model.sv
// Host-side requester that issues configuration reads and writes.
// Assumes the bank answers every request exactly one cycle after it is taken.
`default_nettype none
module pcfg_root_model (
	input wire logic mclk,
	input wire pcfg_pkg::pcfg_rsp_t rsp,
	output var pcfg_pkg::pcfg_req_t req
);
	timeunit 1ns;
	timeprecision 1ps;

	initial begin
		req = '0;
	end

	// ----------------------------------------
	// Single access
	// ----------------------------------------
	// Valid drops on the taking edge, since a level still high there is a second request
	task automatic access(input logic wr, input logic [11:0] adr, input logic [3:0] be, input logic [31:0] wd,
		input int gap, output logic ackSeen, output logic [31:0] rd);
		repeat (gap) @(posedge mclk);
		@(posedge mclk);
		req <= '{valid: 1'b1, write: wr, addr: adr, be: be, wdata: wd};
		@(posedge mclk);
		req.valid <= 1'b0;
		// Released lines show the inverse so stale values cannot pass
		req.addr <= ~adr;
		req.wdata <= ~wd;
		// Answer stands from the taking edge to the next one
		@(negedge mclk);
		ackSeen = rsp.ack;
		rd = rsp.rdata;
	endtask : access

	// ----------------------------------------
	// Write followed by a read on the next edge
	// ----------------------------------------
	task automatic writeThenRead(input logic [11:0] adr, input logic [3:0] be, input logic [31:0] wd,
		output logic ackW, output logic ackR, output logic [31:0] rd);
		@(posedge mclk);
		req <= '{valid: 1'b1, write: 1'b1, addr: adr, be: be, wdata: wd};
		@(posedge mclk);
		req <= '{valid: 1'b1, write: 1'b0, addr: adr, be: 4'h0, wdata: ~wd};
		@(negedge mclk);
		ackW = rsp.ack;
		@(posedge mclk);
		req.valid <= 1'b0;
		req.addr <= ~adr;
		@(negedge mclk);
		ackR = rsp.ack;
		rd = rsp.rdata;
	endtask : writeThenRead
endmodule : pcfg_root_model
`default_nettype wire

// file: testbench/test_pcie_config_space_map.sv
// Self-checking bench for the configuration-space bank.
// Assumes default design parameters and the requester model beside it.
`default_nettype none
`define CHK(got, exp) \
	begin \
		nChecks++; \
		if ((got) !== (exp)) begin \
			nErrors++; \
			$display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); \
		end \
	end
module test_pcie_config_space_map;
	timeunit 1ns;
	timeprecision 1ps;

	typedef struct packed {
		logic wr;
		logic [11:0] adr;
		logic [3:0] be;
		logic [31:0] wd;
		logic [31:0] msk;
		logic [31:0] exp;
	} pcfg_row_t;

	logic mclk = 1'b0;
	logic srst = 1'b1;
	pcfg_pkg::pcfg_req_t req;
	pcfg_pkg::pcfg_rsp_t rsp;
	logic loadValid = 1'b0;
	logic [1:0] loadSel = 2'h0;
	logic [15:0] loadData = 16'h0000;
	pcfg_pkg::pcfg_evt_t evt = '0;
	pcfg_pkg::pcfg_ctl_t ctl;
	int nErrors = 0;
	int nChecks = 0;
	pcfg_row_t rows [24];

	always #5 mclk = ~mclk;

	pcfg_config_space dut_u (
		.mclk(mclk),
		.srst(srst),
		.req(req),
		.rsp(rsp),
		.loadValid(loadValid),
		.loadSel(loadSel),
		.loadData(loadData),
		.evt(evt),
		.ctl(ctl)
	);

	pcfg_root_model hostU (
		.mclk(mclk),
		.rsp(rsp),
		.req(req)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic completeRun();
		$display("checks=%0d errors=%0d", nChecks, nErrors);
		if (nErrors == 0 && nChecks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : completeRun

	task automatic acc(input logic wr, input logic [11:0] a, input logic [3:0] be, input logic [31:0] d,
		output logic [31:0] rd);
		logic ack;
		hostU.access(wr, a, be, d, 0, ack, rd);
		`CHK(ack, 1'b1);
	endtask : acc

	task automatic expRead(input logic [11:0] a, input logic [31:0] msk, input logic [31:0] exp);
		logic [31:0] rd;
		acc(1'b0, a, 4'h0, 32'h0000_0000, rd);
		`CHK(rd & msk, exp);
	endtask : expRead

	task automatic autoload(input logic [1:0] sel, input logic [15:0] d);
		@(posedge mclk);
		loadValid <= 1'b1;
		loadSel <= sel;
		loadData <= d;
		@(posedge mclk);
		loadValid <= 1'b0;
	endtask : autoload

	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] rd;
		logic ackW;
		logic ackR;
		rows = '{
			'{1'b0, 12'h000, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h3C4D_1A2B},
			'{1'b1, 12'h000, 4'hF, 32'hFFFF_FFFF, 32'h0, 32'h0},
			'{1'b0, 12'h000, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h3C4D_1A2B},
			'{1'b0, 12'h004, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0010_0000},
			'{1'b0, 12'h008, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0700_0200},
			'{1'b0, 12'h034, 4'h0, 32'h0, 32'h0000_00FF, 32'h0000_0080},
			'{1'b0, 12'h080, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_8C01},
			'{1'b0, 12'h08C, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_9C05},
			'{1'b0, 12'h09C, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_A403},
			'{1'b0, 12'h0A4, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_E009},
			'{1'b0, 12'h0E0, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_0010},
			'{1'b0, 12'h100, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0001_0001},
			'{1'b0, 12'h018, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0},
			'{1'b1, 12'h0F4, 4'hF, 32'hFFFF_FFFF, 32'h0, 32'h0},
			'{1'b0, 12'h0F4, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0},
			'{1'b0, 12'h104, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0},
			'{1'b1, 12'h114, 4'hF, 32'hFFFF_FFFF, 32'h0, 32'h0},
			'{1'b0, 12'h114, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF},
			'{1'b1, 12'h118, 4'hF, 32'hA5A5_A5A5, 32'h0, 32'h0},
			'{1'b0, 12'h118, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'hA5A5_A5A5},
			'{1'b0, 12'h12C, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h0},
			'{1'b0, 12'h03C, 4'h0, 32'h0, 32'h0000_FFFF, 32'h0000_0100},
			'{1'b1, 12'h090, 4'hF, 32'h1234_5677, 32'h0, 32'h0},
			'{1'b0, 12'h090, 4'h0, 32'h0, 32'hFFFF_FFFF, 32'h1234_5674}
		};
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		@(posedge mclk);
		foreach (rows[i]) begin
			acc(rows[i].wr, rows[i].adr, rows[i].be, rows[i].wd, rd);
			`CHK(rd & rows[i].msk, rows[i].exp);
		end
		// Byte enables pick single bytes
		acc(1'b1, 12'h094, 4'h2, 32'hAABB_CCDD, rd);
		expRead(12'h094, 32'hFFFF_FFFF, 32'h0000_CC00);
		// Write seen by the read on the very next edge
		hostU.writeThenRead(12'h004, 4'h3, 32'h0000_FFFF, ackW, ackR, rd);
		`CHK({ackW, ackR}, 2'h3);
		`CHK(rd, 32'h0010_0543);
		`CHK({ctl.ioEn, ctl.memEn, ctl.parityEn, ctl.serrEn, ctl.intDisable}, 5'h1F);
		hostU.writeThenRead(12'h114, 4'hF, 32'h0F0F_0F0F, ackW, ackR, rd);
		`CHK({ackW, ackR}, 2'h3);
		`CHK(rd, 32'h0F0F_0F0F);
		// Status event, live pending level, write-one clear
		@(posedge mclk);
		evt.sigTargetAbort <= 1'b1;
		evt.intPending <= 1'b1;
		@(posedge mclk);
		evt.sigTargetAbort <= 1'b0;
		expRead(12'h004, 32'h0808_0000, 32'h0808_0000);
		acc(1'b1, 12'h004, 4'h8, 32'h0800_0000, rd);
		evt.intPending <= 1'b0;
		expRead(12'h004, 32'h0808_0000, 32'h0);
		// Error status with header capture, then clear
		@(posedge mclk);
		evt.tlpHeader <= {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
		evt.uncorrSet <= 32'h0000_0010;
		evt.corrSet <= 32'h0000_0041;
		@(posedge mclk);
		evt.uncorrSet <= 32'h0;
		evt.corrSet <= 32'h0;
		expRead(12'h104, 32'hFFFF_FFFF, 32'h0000_0010);
		for (int i = 0; i < 4; i++) begin
			expRead(12'h11C + 12'(4 * i), 32'hFFFF_FFFF, 32'h1111_1111 * (i + 1));
		end
		acc(1'b1, 12'h104, 4'hF, 32'h0000_0010, rd);
		expRead(12'h104, 32'hFFFF_FFFF, 32'h0);
		expRead(12'h110, 32'hFFFF_FFFF, 32'h0000_0041);
		acc(1'b1, 12'h110, 4'hF, 32'h0000_0001, rd);
		expRead(12'h110, 32'hFFFF_FFFF, 32'h0000_0040);
		// Autoload replaces both ids; select 3 is dropped
		autoload(2'h0, 16'h5A5A);
		autoload(2'h1, 16'hA5A5);
		autoload(2'h3, 16'h0F0F);
		expRead(12'h000, 32'hFFFF_FFFF, 32'hA5A5_5A5A);
		// Reset in mid-run
		@(posedge mclk);
		srst <= 1'b1;
		repeat (2) @(posedge mclk);
		`CHK(rsp.ack, 1'b0);
		`CHK(ctl, pcfg_pkg::pcfg_ctl_t'(0));
		srst <= 1'b0;
		@(posedge mclk);
		expRead(12'h004, 32'hFFFF_FFFF, 32'h0010_0000);
		expRead(12'h000, 32'hFFFF_FFFF, 32'h3C4D_1A2B);
		completeRun();
	end

	// ----------------------------------------
	// Watchdog
	// ----------------------------------------
	initial begin
		repeat (5000) @(posedge mclk);
		nErrors++;
		completeRun();
	end
endmodule : test_pcie_config_space_map
`default_nettype wire
